// File: test/derc_host_model.sv
// Host model: sends command frames on the byte stream and gathers replies.
// Assumes the block answers at node address 0x80, with a CRC-16 trailer on read replies only.
`timescale 1ns/1ps
module derc_host_model (
  input wire logic sys_clk,
  output logic [7:0] rx_data,
  output logic rx_valid,
  input wire logic rx_ready,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready
);
  import derc_pkg::*;
  logic [15:0] crc = 16'h0000;
  bit slow = 1'b0;
  initial begin
    rx_data = 8'h00;
    rx_valid = 1'b0;
    tx_ready = 1'b0;
  end
  task automatic crc_add(input logic [7:0] b);
    crc = crc ^ {b, 8'h00};
    for (int i = 0; i < 8; i++) begin
      crc = {crc[14:0], 1'b0} ^ (crc[15] ? CRC_POLY : 16'h0000);
    end
  endtask : crc_add
  // Holds the byte until an edge sees rx_ready
  task automatic put_byte(input logic [7:0] b, inout bit ok);
    bit hit;
    hit = 1'b0;
    crc_add(b);
    rx_data <= b;
    rx_valid <= 1'b1;
    for (int n = 0; n < 200 && !hit; n++) begin
      @(posedge sys_clk);
      hit = rx_ready;
    end
    ok &= hit;
  endtask : put_byte
  // Slow mode stalls three cycles before accepting each byte
  task automatic get_byte(output logic [7:0] b, inout bit ok);
    bit hit;
    hit = 1'b0;
    if (slow) begin
      tx_ready <= 1'b0;
      repeat (3) @(posedge sys_clk);
    end
    tx_ready <= 1'b1;
    for (int n = 0; n < 200 && !hit; n++) begin
      @(posedge sys_clk);
      hit = tx_valid;
    end
    b = tx_data;
    ok &= hit;
  endtask : get_byte
  task automatic send_head(input logic [7:0] cmd, output bit ok);
    ok = 1'b1;
    crc = CRC_INIT;
    put_byte(8'h80, ok);
    put_byte(cmd, ok);
  endtask : send_head
  // Released data lines show a changed value, not the last byte
  task automatic release_rx;
    rx_valid <= 1'b0;
    rx_data <= ~rx_data;
  endtask : release_rx
  task automatic read_cmd(input logic [7:0] cmd, input int len, output logic [63:0] d,
      output logic [15:0] got, output logic [15:0] exp, output bit ok);
    logic [7:0] b;
    d = '0;
    send_head(cmd, ok);
    release_rx();
    for (int i = 0; i < len; i++) begin
      get_byte(b, ok);
      crc_add(b);
      d = {d[55:0], b};
    end
    exp = crc;
    get_byte(got[15:8], ok);
    get_byte(got[7:0], ok);
    tx_ready <= 1'b0;
  endtask : read_cmd
  task automatic write_cmd(input logic [7:0] cmd, input int n, input logic [31:0] v,
      input bit bad, output logic [7:0] ack, output bit ok);
    logic [15:0] c;
    send_head(cmd, ok);
    for (int i = 0; i < n; i++) begin
      put_byte(v[31 - 8 * i -: 8], ok);
    end
    c = crc ^ {15'h0000, bad};
    put_byte(c[15:8], ok);
    put_byte(c[7:0], ok);
    release_rx();
    get_byte(ack, ok);
    tx_ready <= 1'b0;
  endtask : write_cmd
endmodule : derc_host_model

// File: test/derc_top_tb.sv
// Testbench for the encoder readout block: command table, then edge cases.
// Assumes a short speed window so rates settle within a few hundred cycles.
`timescale 1ns/1ps
module derc_top_tb;
  import derc_pkg::*;
  localparam int WIN = 50;
  typedef struct {logic [7:0] cmd; int len; logic [63:0] val;} derc_row_s;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic [1:0] q1 = 2'b00, q2 = 2'b00, ph1 = 2'b00, ph2 = 2'b00;
  logic [11:0] abs1_code = 12'hFFF, abs2_code = 12'h3FF;
  logic [7:0] rx_data, tx_data;
  logic rx_valid, rx_ready, tx_valid, tx_ready;
  logic [4:0] reg_addr = 5'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0, reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [63:0] msk = '1;
  int fails = 0;
  int total_checks = 0;
  derc_row_s rows[8] = '{
    '{CMD_CNT1, 5, 64'h0000_00FF_FFFF_FF03},
    '{CMD_CNT2, 5, 64'h0000_0000_0000_0100},
    '{CMD_SPD1, 5, 64'h0000_0000_0000_0001},
    '{CMD_SPD2, 5, 64'h0000_0000_0000_0000},
    '{CMD_RAW1, 5, 64'h0000_0000_0000_0001},
    '{CMD_RAW2, 5, 64'h0000_0000_0000_0000},
    '{CMD_CNTS, 8, 64'hFFFF_FFFF_0000_0001},
    '{CMD_SPDS, 8, 64'h0000_0000_0000_0000}};
  initial begin
    forever #4 sys_clk = ~sys_clk;
  end
  derc_top #(.WINDOW_CYC(WIN)) u_dut (
    .sys_clk(sys_clk), .rst(rst), .ce(ce),
    .quad1_a(q1[1]), .quad1_b(q1[0]), .quad2_a(q2[1]), .quad2_b(q2[0]),
    .abs1_code(abs1_code), .abs2_code(abs2_code),
    .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));
  derc_host_model u_host (
    .sys_clk(sys_clk), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready));
  task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic results;
    if (fails == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : results
  // One quadrature step in gray order, then a settle gap of five cycles
  task automatic step(input bit ch2, input bit fwd);
    if (ch2) ph2 = fwd ? ph2 + 2'd1 : ph2 - 2'd1;
    else ph1 = fwd ? ph1 + 2'd1 : ph1 - 2'd1;
    q1 <= {ph1[1], ^ph1};
    q2 <= {ph2[1], ^ph2};
    repeat (5) @(posedge sys_clk);
  endtask : step
  task automatic reg_read(input logic [4:0] a, input logic [31:0] exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
    check("reg_rdata", {32'h0, exp}, {32'h0, reg_rdata});
  endtask : reg_read
  task automatic reg_write(input logic [4:0] a, input logic [31:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask : reg_write
  task automatic rd(input logic [7:0] cmd, input int len, input logic [63:0] exp);
    logic [63:0] d;
    logic [15:0] g, e;
    bit ok;
    u_host.read_cmd(cmd, len, d, g, e, ok);
    check("reply seen", 64'h1, {63'h0, ok});
    check("reply data", exp & msk, d & msk);
    check("reply crc", {48'h0, e}, {48'h0, g});
  endtask : rd
  task automatic wr(input logic [7:0] cmd, input int n, input logic [31:0] v, input bit bad);
    logic [7:0] a;
    bit ok;
    u_host.write_cmd(cmd, n, v, bad, a, ok);
    check("reply seen", {63'h0, !bad}, {63'h0, ok});
    if (!bad) check("ack", {56'h0, ACK_BYTE}, {56'h0, a});
  endtask : wr
  initial begin
    repeat (16) @(posedge sys_clk);
    check("rx_ready", 64'h1, {63'h0, rx_ready});
    check("tx_valid", 64'h0, {63'h0, tx_valid});
    rst <= 1'b0;
    reg_read(REG_CTRL, CTRL_RST);
    reg_read(5'h1C, 32'h0000_0000);
    step(0, 0);
    step(1, 1);
    repeat (1000) @(posedge sys_clk);
    foreach (rows[i]) rd(rows[i].cmd, rows[i].len, rows[i].val);
    rd(CMD_CNT1, 5, 64'h0000_00FF_FFFF_FF02);
    wr(CMD_PRE1, 4, 32'hFFFF_FFFF, 1'b0);
    step(0, 1);
    rd(CMD_CNT1, 5, 64'h0000_0000_0000_0004);
    rd(CMD_CNT1, 5, 64'h0000_0000_0000_0000);
    wr(CMD_PRE2, 4, 32'h1234_5678, 1'b0);
    reg_write(REG_CNT2, 32'hAAAA_AAAA);
    reg_read(REG_CNT2, 32'h1234_5678);
    wr(CMD_CLR, 0, 32'h0000_0000, 1'b1);
    reg_read(REG_CNT2, 32'h1234_5678);
    wr(CMD_CLR, 0, 32'h0000_0000, 1'b0);
    reg_read(REG_CNT1, 32'h0000_0000);
    reg_read(REG_CNT2, 32'h0000_0000);
    u_host.slow = 1'b1;
    fork
      repeat (40) step(1'b1, 1'b1);
      begin
        repeat (120) @(posedge sys_clk);
        reg_read(REG_RAW2, 32'h0000_0BB8);
        rd(CMD_RAW2, 5, 64'h0000_0000_000B_B800);
      end
    join
    u_host.slow = 1'b0;
    ce <= 1'b0;
    step(0, 1);
    step(0, 1);
    ce <= 1'b1;
    reg_read(REG_CNT1, 32'h0000_0000);
    reg_write(REG_CTRL, 32'h0000_8003);
    msk = 64'hFFFF_FFFF_FFFF_FF00;
    rd(CMD_CNT1, 5, 64'h0000_0000_000F_FF00);
    rd(CMD_CNT2, 5, 64'h0000_0000_0003_FF00);
    msk = '1;
    rd(CMD_CNTS, 8, 64'h0000_07FF_0000_0517);
    rst <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    reg_read(REG_CTRL, CTRL_RST);
    reg_read(REG_CNT2, 32'h0000_0000);
    rd(CMD_CNT2, 5, 64'h0000_0000_0000_0000);
    results();
  end
endmodule : derc_top_tb

// File: verilog/derc_pkg.sv
// Shared constants for the dual encoder readout and command block.
// Assumes one 125 MHz clock and a byte-wide packet link to the host.
package derc_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 125_000_000;
  localparam int WINDOW_HZ = 300;
  localparam int WINDOW_CYC = CLK_HZ / WINDOW_HZ;

  // ----------------------------------------------------------------
  // Command numbers
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_CNT1 = 8'h10;
  localparam logic [7:0] CMD_CNT2 = 8'h11;
  localparam logic [7:0] CMD_SPD1 = 8'h12;
  localparam logic [7:0] CMD_SPD2 = 8'h13;
  localparam logic [7:0] CMD_CLR = 8'h14;
  localparam logic [7:0] CMD_PRE1 = 8'h16;
  localparam logic [7:0] CMD_PRE2 = 8'h17;
  localparam logic [7:0] CMD_RAW1 = 8'h1E;
  localparam logic [7:0] CMD_RAW2 = 8'h1F;
  localparam logic [7:0] CMD_CNTS = 8'h4E;
  localparam logic [7:0] CMD_SPDS = 8'h4F;
  localparam logic [7:0] ACK_BYTE = 8'hFF;

  // ----------------------------------------------------------------
  // Frame layout and checksum
  // ----------------------------------------------------------------
  localparam logic [2:0] PAY_LAST = 3'h3;
  localparam logic [3:0] LEN_ACK = 4'h1;
  localparam logic [3:0] LEN_ONE = 4'h5;
  localparam logic [3:0] LEN_TWO = 4'h8;
  localparam logic [3:0] LEN_CRC = 4'h2;
  localparam logic [3:0] LEN_LAST = 4'h1;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_INIT = 16'h0000;

  // ----------------------------------------------------------------
  // Status byte and absolute scaling
  // ----------------------------------------------------------------
  localparam int ST_UNDER = 0;
  localparam int ST_DIR = 1;
  localparam int ST_OVER = 2;
  localparam logic [31:0] CNT_MAX = 32'hFFFF_FFFF;
  localparam logic [11:0] ABS_NUM = 12'h519;
  localparam int ABS_SHIFT = 10;
  localparam logic [10:0] ABS_SAT = 11'h7FF;

  // ----------------------------------------------------------------
  // Register port map
  // ----------------------------------------------------------------
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_STAT = 5'h04;
  localparam logic [4:0] REG_CNT1 = 5'h08;
  localparam logic [4:0] REG_CNT2 = 5'h0C;
  localparam logic [4:0] REG_RAW1 = 5'h10;
  localparam logic [4:0] REG_RAW2 = 5'h14;
  localparam int CTRL_ABS1 = 0;
  localparam int CTRL_ABS2 = 1;
  localparam int CTRL_NODE = 8;
  localparam logic [31:0] CTRL_RST = 32'h0000_8000;

  typedef enum logic [2:0] {
    DERC_ADDR, DERC_CMD, DERC_PAY, DERC_CRCH, DERC_CRCL, DERC_TX
  } derc_state_e;

endpackage : derc_pkg

// File: verilog/derc_quad_channel.sv
// One encoder channel: quadrature counter, sticky flags, window speed.
// Assumes quadrature and absolute inputs are synchronous to sys_clk.
`timescale 1ns/1ps
module derc_quad_channel #(
  parameter int WINDOW_CYC = derc_pkg::WINDOW_CYC
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic quad_a,
  input wire logic quad_b,
  input wire logic abs_mode,
  input wire logic [11:0] abs_code,
  input wire logic load,
  input wire logic [31:0] load_val,
  input wire logic [1:0] flag_clr,
  output logic [31:0] count_value,
  output logic [7:0] status,
  output logic [31:0] raw_rate,
  output logic [31:0] filt_rate,
  output logic dir
);
  import derc_pkg::*;

  localparam int WW = $clog2(WINDOW_CYC);

  logic [1:0] prev_ab;
  logic [31:0] count;
  logic under;
  logic over;
  logic [WW-1:0] wcnt;
  logic [23:0] acc;

  // ----------------------------------------------------------------
  // Quadrature step decode
  // ----------------------------------------------------------------
  wire [3:0] trans = {prev_ab, quad_a, quad_b};
  wire fwd = !abs_mode && (trans == 4'h1 || trans == 4'h7 || trans == 4'hE || trans == 4'h8);
  wire bwd = !abs_mode && (trans == 4'h2 || trans == 4'hB || trans == 4'hD || trans == 4'h4);
  wire do_load = load && !abs_mode;
  wire over_set = fwd && !do_load && count == CNT_MAX;
  wire under_set = bwd && !do_load && count == 32'h0000_0000;
  wire win_end = wcnt == WW'(WINDOW_CYC - 1);
  wire [23:0] next_acc = acc + (fwd ? 24'h00_0001 : 24'h00_0000)
    - (bwd ? 24'h00_0001 : 24'h00_0000);
  wire [23:0] mag = next_acc[23] ? 24'h00_0000 - next_acc : next_acc;
  wire [31:0] next_raw = 32'(mag) * 32'(WINDOW_HZ);
  wire [32:0] filt_sum = {1'b0, filt_rate} + {1'b0, next_raw};

  assign count_value = abs_mode ? {20'h0_0000, abs_code} : count;
  assign status = {5'h00, over, dir, under};

  // ----------------------------------------------------------------
  // Counter and flags
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      // Track the pins so release gives no false step
      prev_ab <= {quad_a, quad_b};
      count <= 32'h0000_0000;
      under <= 1'b0;
      over <= 1'b0;
      dir <= 1'b0;
    end else if (ce) begin
      prev_ab <= {quad_a, quad_b};
      if (do_load) begin
        count <= load_val;
      end else if (fwd) begin
        count <= count + 32'h0000_0001;
      end else if (bwd) begin
        count <= count - 32'h0000_0001;
      end
      under <= (under && !flag_clr[0]) || under_set;
      over <= (over && !flag_clr[1]) || over_set;
      if (fwd || bwd) begin
        dir <= bwd;
      end
    end
  end

  // ----------------------------------------------------------------
  // Speed window
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wcnt <= '0;
      acc <= 24'h00_0000;
      raw_rate <= 32'h0000_0000;
      filt_rate <= 32'h0000_0000;
    end else if (ce) begin
      if (win_end) begin
        wcnt <= '0;
        acc <= 24'h00_0000;
        raw_rate <= next_raw;
        filt_rate <= filt_sum[32:1];
      end else begin
        wcnt <= wcnt + WW'(1);
        acc <= next_acc;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  AST_WRAP_OVER: assert property (ce && over_set |=> over && count == 32'h0000_0000)
    else $error("overflow wrap not flagged");
  AST_WRAP_UNDER: assert property (ce && under_set |=> under && count == CNT_MAX)
    else $error("underflow wrap not flagged");
  AST_SET_WINS: assert property (ce && over_set && flag_clr[1] |=> over)
    else $error("overflow lost against clear");
  AST_LOAD: assert property (ce && do_load |=> count == $past(load_val))
    else $error("preset value not loaded");
  AST_RESERVED: assert property (status[7:3] == 5'h00)
    else $error("reserved status bits not zero");
  AST_RAW: assert property (ce && win_end |=> raw_rate == $past(next_raw)
    && raw_rate % WINDOW_HZ == 0)
    else $error("raw rate not scaled from window");

endmodule : derc_quad_channel

// File: verilog/derc_top.sv
// Dual encoder readout with a packet command engine and a register port.
// Assumes host bytes arrive on a valid/ready stream and leave the same way.
`timescale 1ns/1ps
module derc_top #(
  parameter int WINDOW_CYC = derc_pkg::WINDOW_CYC
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic quad1_a,
  input wire logic quad1_b,
  input wire logic quad2_a,
  input wire logic quad2_b,
  input wire logic [11:0] abs1_code,
  input wire logic [11:0] abs2_code,
  input wire logic [7:0] rx_data,
  input wire logic rx_valid,
  output logic rx_ready,
  output logic [7:0] tx_data,
  output logic tx_valid,
  input wire logic tx_ready,
  input wire logic [4:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata
);
  import derc_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] derc_crc_step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {d, 8'h00};
    for (int i = 0; i < 8; i++) begin
      r = r[15] ? ((r << 1) ^ CRC_POLY) : (r << 1);
    end
    return r;
  endfunction : derc_crc_step

  function automatic logic derc_known(input logic [7:0] c);
    return c == CMD_CNT1 || c == CMD_CNT2 || c == CMD_SPD1 || c == CMD_SPD2
      || c == CMD_CLR || c == CMD_PRE1 || c == CMD_PRE2 || c == CMD_RAW1
      || c == CMD_RAW2 || c == CMD_CNTS || c == CMD_SPDS;
  endfunction : derc_known

  function automatic logic derc_is_write(input logic [7:0] c);
    return c == CMD_CLR || c == CMD_PRE1 || c == CMD_PRE2;
  endfunction : derc_is_write

  function automatic logic [10:0] derc_abs_scale(input logic [11:0] code);
    logic [23:0] prod;
    logic [13:0] q;
    prod = code * ABS_NUM;
    q = prod[ABS_SHIFT +: 14];
    return (q > 14'(ABS_SAT)) ? ABS_SAT : q[10:0];
  endfunction : derc_abs_scale

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  derc_state_e state;
  logic [7:0] cmd;
  logic [31:0] pay;
  logic [2:0] pay_cnt;
  logic [15:0] crc;
  logic [7:0] crc_hi;
  logic [71:0] buf_q;
  logic [3:0] dcnt;
  logic with_crc;
  logic in_crc;
  logic clr_on_last;
  logic clr_ch;
  logic [1:0] clr_mask;
  logic [31:0] ctrl;

  logic [1:0] q_a;
  logic [1:0] q_b;
  logic [1:0] abs_mode;
  logic [11:0] abs_code [2];
  logic [1:0] load;
  logic [1:0] flag_clr [2];
  logic [31:0] cnt [2];
  logic [7:0] stat [2];
  logic [31:0] raw [2];
  logic [31:0] filt [2];
  logic [1:0] dir;

  // ----------------------------------------------------------------
  // Channels
  // ----------------------------------------------------------------
  assign q_a = {quad2_a, quad1_a};
  assign q_b = {quad2_b, quad1_b};
  assign abs_mode = {ctrl[CTRL_ABS2], ctrl[CTRL_ABS1]};
  assign abs_code[0] = abs1_code;
  assign abs_code[1] = abs2_code;

  wire rx_fire = rx_valid && rx_ready && ce;
  wire tx_fire = tx_valid && tx_ready && ce;
  wire [7:0] node = ctrl[CTRL_NODE +: 8];
  wire [15:0] rx_crc = derc_crc_step(crc, rx_data);
  wire [15:0] tx_crc = derc_crc_step(crc, tx_data);
  wire frame_ok = rx_fire && state == DERC_CRCL && {crc_hi, rx_data} == crc;
  wire clr_fire = tx_fire && !in_crc && clr_on_last && dcnt == LEN_LAST;

  generate
    for (genvar g = 0; g < 2; g++) begin : g_ch
      assign load[g] = frame_ok && (cmd == CMD_CLR
        || (cmd == (g == 0 ? CMD_PRE1 : CMD_PRE2)));
      assign flag_clr[g] = (clr_fire && clr_ch == 1'(g)) ? clr_mask : 2'h0;
      derc_quad_channel #(
        .WINDOW_CYC(WINDOW_CYC)
      ) u_ch (
        .sys_clk(sys_clk),
        .rst(rst),
        .ce(ce),
        .quad_a(q_a[g]),
        .quad_b(q_b[g]),
        .abs_mode(abs_mode[g]),
        .abs_code(abs_code[g]),
        .load(load[g]),
        .load_val(cmd == CMD_CLR ? 32'h0000_0000 : pay),
        .flag_clr(flag_clr[g]),
        .count_value(cnt[g]),
        .status(stat[g]),
        .raw_rate(raw[g]),
        .filt_rate(filt[g]),
        .dir(dir[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Response build
  // ----------------------------------------------------------------
  wire [7:0] cmd_now = (state == DERC_CMD) ? rx_data : cmd;
  wire ch = cmd_now[0];
  wire [31:0] cnt78_1 = abs_mode[0] ? {21'h00_0000, derc_abs_scale(abs1_code)} : cnt[0];
  wire [31:0] cnt78_2 = abs_mode[1] ? {21'h00_0000, derc_abs_scale(abs2_code)} : cnt[1];
  wire [7:0] dir_byte = {7'h00, dir[ch]};
  wire is_cnt = cmd_now == CMD_CNT1 || cmd_now == CMD_CNT2;
  wire is_spd = cmd_now == CMD_SPD1 || cmd_now == CMD_SPD2;
  wire is_raw = cmd_now == CMD_RAW1 || cmd_now == CMD_RAW2;
  logic [71:0] next_buf;
  logic [3:0] next_len;

  always_comb begin
    next_buf = {ACK_BYTE, 64'h0000_0000_0000_0000};
    next_len = LEN_ACK;
    if (is_cnt) begin
      next_buf = {cnt[ch], stat[ch], 32'h0000_0000};
      next_len = LEN_ONE;
    end else if (is_spd) begin
      next_buf = {filt[ch], dir_byte, 32'h0000_0000};
      next_len = LEN_ONE;
    end else if (is_raw) begin
      next_buf = {raw[ch], dir_byte, 32'h0000_0000};
      next_len = LEN_ONE;
    end else if (cmd_now == CMD_CNTS) begin
      next_buf = {cnt78_1, cnt78_2, 8'h00};
      next_len = LEN_TWO;
    end else if (cmd_now == CMD_SPDS) begin
      next_buf = {raw[0], raw[1], 8'h00};
      next_len = LEN_TWO;
    end
  end

  // ----------------------------------------------------------------
  // Command engine
  // ----------------------------------------------------------------
  assign rx_ready = state != DERC_TX;
  assign tx_valid = state == DERC_TX;
  assign tx_data = buf_q[71:64];

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state <= DERC_ADDR;
      cmd <= 8'h00;
      pay <= 32'h0000_0000;
      pay_cnt <= 3'h0;
      crc <= CRC_INIT;
      crc_hi <= 8'h00;
      buf_q <= 72'h00_0000_0000_0000_0000;
      dcnt <= 4'h0;
      with_crc <= 1'b0;
      in_crc <= 1'b0;
      clr_on_last <= 1'b0;
      clr_ch <= 1'b0;
      clr_mask <= 2'h0;
    end else if (ce) begin
      unique case (state)
        DERC_ADDR: begin
          if (rx_fire && rx_data == node) begin
            crc <= derc_crc_step(CRC_INIT, rx_data);
            state <= DERC_CMD;
          end
        end
        DERC_CMD: begin
          if (rx_fire) begin
            cmd <= rx_data;
            crc <= rx_crc;
            pay_cnt <= 3'h0;
            if (!derc_known(rx_data)) begin
              state <= DERC_ADDR;
            end else if (rx_data == CMD_PRE1 || rx_data == CMD_PRE2) begin
              state <= DERC_PAY;
            end else if (derc_is_write(rx_data)) begin
              state <= DERC_CRCH;
            end else begin
              buf_q <= next_buf;
              dcnt <= next_len;
              with_crc <= 1'b1;
              in_crc <= 1'b0;
              clr_on_last <= is_cnt;
              clr_ch <= ch;
              clr_mask <= {stat[ch][ST_OVER], stat[ch][ST_UNDER]};
              crc <= rx_crc;
              state <= DERC_TX;
            end
          end
        end
        DERC_PAY: begin
          if (rx_fire) begin
            pay <= {pay[23:0], rx_data};
            crc <= rx_crc;
            pay_cnt <= pay_cnt + 3'h1;
            if (pay_cnt == PAY_LAST) begin
              state <= DERC_CRCH;
            end
          end
        end
        DERC_CRCH: begin
          if (rx_fire) begin
            crc_hi <= rx_data;
            state <= DERC_CRCL;
          end
        end
        DERC_CRCL: begin
          if (rx_fire) begin
            if (frame_ok) begin
              buf_q <= next_buf;
              dcnt <= LEN_ACK;
              with_crc <= 1'b0;
              in_crc <= 1'b0;
              clr_on_last <= 1'b0;
              state <= DERC_TX;
            end else begin
              state <= DERC_ADDR;
            end
          end
        end
        DERC_TX: begin
          if (tx_fire) begin
            if (!in_crc) begin
              crc <= tx_crc;
            end
            if (dcnt == LEN_LAST) begin
              if (with_crc && !in_crc) begin
                buf_q <= {tx_crc, 56'h00_0000_0000_0000};
                dcnt <= LEN_CRC;
                in_crc <= 1'b1;
              end else begin
                state <= DERC_ADDR;
              end
            end else begin
              buf_q <= {buf_q[63:0], 8'h00};
              dcnt <= dcnt - 4'h1;
            end
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  wire [31:0] stat_word = {21'h00_0000, stat[1][2:0], 5'h00, stat[0][2:0]};
  logic [31:0] rd_mux;

  always_comb begin
    unique case (reg_addr)
      REG_CTRL: rd_mux = ctrl;
      REG_STAT: rd_mux = stat_word;
      REG_CNT1: rd_mux = cnt[0];
      REG_CNT2: rd_mux = cnt[1];
      REG_RAW1: rd_mux = raw[0];
      REG_RAW2: rd_mux = raw[1];
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl <= CTRL_RST;
      reg_rdata <= 32'h0000_0000;
    end else if (ce) begin
      if (reg_wr && reg_addr == REG_CTRL) begin
        ctrl <= reg_wdata;
      end
      reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_clear_frame;
    ce && frame_ok && cmd == CMD_CLR;
  endsequence

  sequence s_ack_out;
    tx_valid && tx_data == ACK_BYTE && dcnt == LEN_ACK && !with_crc;
  endsequence

  AST_CLEAR_BOTH: assert property (s_clear_frame |-> load == 2'h3)
    else $error("clear did not reach both counters");
  AST_CLEAR_ACK: assert property (s_clear_frame |=> s_ack_out)
    else $error("clear not acknowledged with ack byte");
  AST_NO_RX_IN_TX: assert property (tx_valid |-> !rx_ready)
    else $error("host bytes accepted while answering");
  AST_CNT_LEN: assert property (ce && rx_fire && state == DERC_CMD && is_cnt
    |=> tx_valid && dcnt == LEN_ONE && with_crc)
    else $error("count reply length wrong");
  AST_PAIR_LEN: assert property (ce && rx_fire && state == DERC_CMD
    && (cmd_now == CMD_CNTS || cmd_now == CMD_SPDS) |=> dcnt == LEN_TWO)
    else $error("combined reply length wrong");
  AST_RD_ONE: assert property (ce && !reg_rd |=> reg_rdata == 32'h0000_0000)
    else $error("read data outside its cycle");

endmodule : derc_top
